/* File: pecs_regs.sv */
`timescale 1ns/1ps
// Operation
// - bit 15 disables the transmitter
// - bits 14:10 bypass the pcs stages
// - bit 9 bypasses link fail inhibit timer
// - sticky bit 7 disables automatic crossover, default one
// - sticky bits 6:4 disable legacy, swap, polarity
// - sticky bit 3 honours advertised ability, default one
// - bit 2 disables pulse shaping filter
// - sticky bit 1 selects manual next pages
// - counters saturate at 255, clear on read
// - counters at 19, 20 and 21
// - sticky bit 15 forces ten base link pass
// - sticky jabber, echo and sqe disables
// - sticky squelch field selects threshold
// - sticky reset enable keeps sticky bits
// - super sticky bits survive every soft reset
// - eof, disconnect flags and live link status
// - broadcast bit spreads writes to all phys
// - reads are answered whichever phy is addressed, broadcast or not
// - writing register 0 bit 15 soft resets
module pecs_regs #(
    parameter int NUM_PHY = 2,
    parameter int PHY_IDX = 0
) (
    input  wire logic                               clk_sys,
    input  wire logic                               rst_n,
    input  wire pecs_pkg::pecs_mgmt_t               mgmt,
    input  wire pecs_pkg::pecs_evt_t                evt,
    output logic [pecs_pkg::DATA_W-1:0]             rdata,
    output logic                                    rvalid,
    output logic                                    bcast_en,
    output pecs_pkg::pecs_ctrl_t                    ctrl
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_pipe_q;
    logic       rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_q[1];

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [pecs_pkg::DATA_W-1:0] bypass;
        logic [pecs_pkg::DATA_W-1:0] ten;
        logic [pecs_pkg::DATA_W-1:0] rdata;
        logic                        rvalid;
        pecs_pkg::pecs_ctrl_t        ctrl;
    } pecs_state_t;

    pecs_state_t st_q;
    pecs_state_t st_d;

    // a write lands here when it is ours, or any phy's while broadcasting
    logic wr_hit;
    logic rd_hit;
    logic soft_rst;
    logic rd_ten;
    logic [2:0] cnt_clr;
    logic [2:0] cnt_inc;
    logic [pecs_pkg::CNT_W-1:0] cnt_val [3];

    assign wr_hit   = mgmt.wr && (mgmt.bcast || st_q.ten[pecs_pkg::TEN_BCAST_BIT]);
    assign rd_hit   = mgmt.rd;
    assign soft_rst = wr_hit && mgmt.addr == pecs_pkg::ADDR_CTRL
                      && mgmt.wdata[pecs_pkg::SOFT_RESET_BIT];
    assign rd_ten   = rd_hit && mgmt.addr == pecs_pkg::ADDR_TEN_CTRL;
    assign cnt_inc  = {evt.link_disconnect, evt.false_carrier, evt.rx_error};

    // ************************************************************
    // error counters
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            assign cnt_clr[gi] = rd_hit
                && mgmt.addr == pecs_pkg::ADDR_RX_ERR_CNT + 5'(gi);
            pecs_sat_counter #(
                .W (pecs_pkg::CNT_W)
            ) u_cnt (
                .clk_sys    (clk_sys),
                .rst_sync_n (rst_sync_n),
                .clear      (cnt_clr[gi]),
                .inc        (cnt_inc[gi]),
                .count_q    (cnt_val[gi])
            );
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [pecs_pkg::DATA_W-1:0] keep;
        logic [pecs_pkg::DATA_W-1:0] plain_ten_mask;
        keep           = '0;
        plain_ten_mask = '0;
        st_d           = st_q;
        st_d.rvalid    = 1'b0;

        // read mux: counters use the low byte, upper bits read zero
        if (rd_hit) begin
            st_d.rvalid = 1'b1;
            case (mgmt.addr)
                pecs_pkg::ADDR_BYPASS:     st_d.rdata = st_q.bypass;
                pecs_pkg::ADDR_RX_ERR_CNT: st_d.rdata = {8'h00, cnt_val[0]};
                pecs_pkg::ADDR_FALSE_CAR:  st_d.rdata = {8'h00, cnt_val[1]};
                pecs_pkg::ADDR_LINK_DISC:  st_d.rdata = {8'h00, cnt_val[2]};
                pecs_pkg::ADDR_TEN_CTRL:   st_d.rdata = st_q.ten;
                default:                   st_d.rdata = 16'h0000;
            endcase
        end

        // event flags: read clears, a fresh event wins over the clear
        if (rd_ten) begin
            st_d.ten[pecs_pkg::TEN_EOF_BIT]  = 1'b0;
            st_d.ten[pecs_pkg::TEN_DISC_BIT] = 1'b0;
        end
        if (evt.eof_error) begin
            st_d.ten[pecs_pkg::TEN_EOF_BIT] = 1'b1;
        end
        if (evt.ten_disconnect) begin
            st_d.ten[pecs_pkg::TEN_DISC_BIT] = 1'b1;
        end
        st_d.ten[pecs_pkg::TEN_LINK_BIT] = evt.ten_link_active;

        // host writes only touch writable bits
        if (wr_hit && mgmt.addr == pecs_pkg::ADDR_BYPASS) begin
            st_d.bypass = mgmt.wdata & (pecs_pkg::BYP_PLAIN_MASK | pecs_pkg::BYP_STICKY_MASK);
        end
        if (wr_hit && mgmt.addr == pecs_pkg::ADDR_TEN_CTRL) begin
            plain_ten_mask = pecs_pkg::TEN_STICKY_MASK | pecs_pkg::TEN_SUPER_MASK;
            st_d.ten = (st_d.ten & ~plain_ten_mask) | (mgmt.wdata & plain_ten_mask);
        end

        // soft reset: plain bits default, sticky ones if retention is off
        if (soft_rst) begin
            keep = pecs_pkg::TEN_SUPER_MASK;
            if (st_q.ten[pecs_pkg::TEN_STICKY_EN_BIT]) begin
                keep = keep | pecs_pkg::BYP_STICKY_MASK;
            end
            st_d.bypass = (st_q.bypass & keep & pecs_pkg::BYP_STICKY_MASK)
                        | (pecs_pkg::BYP_RESET & ~(keep & pecs_pkg::BYP_STICKY_MASK));
            if (st_q.ten[pecs_pkg::TEN_STICKY_EN_BIT]) begin
                keep = pecs_pkg::TEN_SUPER_MASK | pecs_pkg::TEN_STICKY_MASK;
            end else begin
                keep = pecs_pkg::TEN_SUPER_MASK;
            end
            st_d.ten = (st_q.ten & keep)
                     | (pecs_pkg::TEN_RESET & (pecs_pkg::TEN_STICKY_MASK | pecs_pkg::TEN_SUPER_MASK) & ~keep)
                     | (st_d.ten & ~(pecs_pkg::TEN_STICKY_MASK | pecs_pkg::TEN_SUPER_MASK));
        end

        // decoded controls, registered so outputs come from flops
        st_d.ctrl.tx_disable                     = st_d.bypass[15];
        st_d.ctrl.bypass_4b5b                    = st_d.bypass[14];
        st_d.ctrl.bypass_scrambler               = st_d.bypass[13];
        st_d.ctrl.bypass_descrambler             = st_d.bypass[12];
        st_d.ctrl.bypass_pcs_rx                  = st_d.bypass[11];
        st_d.ctrl.bypass_pcs_tx                  = st_d.bypass[10];
        st_d.ctrl.bypass_link_fail_inhibit_timer = st_d.bypass[9];
        st_d.ctrl.automatic_crossover_forced_off = st_d.bypass[7];
        st_d.ctrl.legacy_detect_off              = st_d.bypass[6];
        st_d.ctrl.pair_swap_off                  = st_d.bypass[5];
        st_d.ctrl.polarity_corr_off              = st_d.bypass[4];
        st_d.ctrl.parallel_detect_honour         = st_d.bypass[3];
        st_d.ctrl.pulse_shaping_off              = st_d.bypass[2];
        // host then owns the next page sequence and the forced setup
        st_d.ctrl.next_page_manual               = st_d.bypass[1];
        st_d.ctrl.force_link_pass                = st_d.ten[15];
        st_d.ctrl.jabber_off                     = st_d.ten[14];
        st_d.ctrl.echo_off                       = st_d.ten[13];
        st_d.ctrl.sqe_off                        = st_d.ten[12];
        st_d.ctrl.squelch_sel                    = st_d.ten[11:10];
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q        <= '0;
            st_q.bypass <= pecs_pkg::BYP_RESET;
            st_q.ten    <= pecs_pkg::TEN_RESET;
            st_q.ctrl.automatic_crossover_forced_off <= 1'b1;
            st_q.ctrl.parallel_detect_honour         <= 1'b1;
            st_q.ctrl.echo_off                       <= 1'b1;
            st_q.ctrl.sqe_off                        <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata    = st_q.rdata;
    assign rvalid   = st_q.rvalid;
    assign bcast_en = st_q.ten[pecs_pkg::TEN_BCAST_BIT];
    assign ctrl     = st_q.ctrl;

endmodule

/* File: pecs_pkg.sv */
package pecs_pkg;

    // ************************************************************
    // register addresses and widths
    // ************************************************************
    localparam int          REG_AW            = 5;
    localparam int          DATA_W            = 16;
    localparam int          CNT_W             = 8;
    localparam logic [4:0]  ADDR_CTRL         = 5'h00;
    localparam logic [4:0]  ADDR_BYPASS       = 5'h12;
    localparam logic [4:0]  ADDR_RX_ERR_CNT   = 5'h13;
    localparam logic [4:0]  ADDR_FALSE_CAR    = 5'h14;
    localparam logic [4:0]  ADDR_LINK_DISC    = 5'h15;
    localparam logic [4:0]  ADDR_TEN_CTRL     = 5'h16;
    localparam int          SOFT_RESET_BIT    = 15;
    localparam logic [7:0]  CNT_MAX           = 8'hff;

    // ************************************************************
    // bypass register fields
    // ************************************************************
    localparam logic [15:0] BYP_PLAIN_MASK    = 16'hfe04;
    localparam logic [15:0] BYP_STICKY_MASK   = 16'h00fa;
    localparam logic [15:0] BYP_RESET         = 16'h0088;

    // ************************************************************
    // ten base t control and status fields
    // ************************************************************
    localparam logic [15:0] TEN_STICKY_MASK   = 16'hfc01;
    localparam logic [15:0] TEN_SUPER_MASK    = 16'h0200;
    localparam logic [15:0] TEN_RESET         = 16'h3200;
    localparam int          TEN_EOF_BIT       = 8;
    localparam int          TEN_DISC_BIT      = 7;
    localparam int          TEN_LINK_BIT      = 6;
    localparam int          TEN_STICKY_EN_BIT = 9;
    localparam int          TEN_BCAST_BIT     = 0;
    localparam logic [1:0]  SQ_NORMAL         = 2'h0;
    localparam logic [1:0]  SQ_LOW            = 2'h1;
    localparam logic [1:0]  SQ_HIGH           = 2'h2;

    // decoded controls driven to the datapath
    typedef struct packed {
        logic       tx_disable;
        logic       bypass_4b5b;
        logic       bypass_scrambler;
        logic       bypass_descrambler;
        logic       bypass_pcs_rx;
        logic       bypass_pcs_tx;
        logic       bypass_link_fail_inhibit_timer;
        logic       automatic_crossover_forced_off;
        logic       legacy_detect_off;
        logic       pair_swap_off;
        logic       polarity_corr_off;
        logic       parallel_detect_honour;
        logic       pulse_shaping_off;
        logic       next_page_manual;
        logic       force_link_pass;
        logic       jabber_off;
        logic       echo_off;
        logic       sqe_off;
        logic [1:0] squelch_sel;
    } pecs_ctrl_t;

    // one-cycle event strobes and the live ten base link level from the datapath
    typedef struct packed {
        logic rx_error;
        logic false_carrier;
        logic link_disconnect;
        logic eof_error;
        logic ten_disconnect;
        logic ten_link_active;
    } pecs_evt_t;

    // management access, one cycle per request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic              bcast;
        logic [REG_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pecs_mgmt_t;

endpackage

/* File: pecs_sat_counter.sv */
`timescale 1ns/1ps
module pecs_sat_counter #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_sync_n,
    input  wire logic         clear,
    input  wire logic         inc,
    output logic [W-1:0]      count_q
);
    logic [W-1:0] count_d;

    // ************************************************************
    // saturating count, read clears, an event on the read cycle is kept
    // ************************************************************
    always_comb begin
        count_d = clear ? '0 : count_q;
        if (inc && count_d != {W{1'b1}}) begin
            count_d = count_d + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

/* File: pecs_regs_sva.sv */
`timescale 1ns/1ps
module pecs_regs_chk (
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire pecs_pkg::pecs_mgmt_t           mgmt,
    input  wire pecs_pkg::pecs_evt_t            evt,
    input  wire logic [pecs_pkg::DATA_W-1:0]    rdata,
    input  wire logic                           rvalid,
    input  wire logic                           bcast_en,
    input  wire pecs_pkg::pecs_ctrl_t           ctrl
);
    // ************************************************************
    // port relations
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // writes land when accepted or when this phy broadcasts
    wire hit = mgmt.wr && (mgmt.bcast || bcast_en);
    wire rd13 = mgmt.rd && mgmt.addr == 5'h13 && !evt.rx_error;

    property p_rvalid; mgmt.rd |=> rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_hold; !mgmt.rd |=> $stable(rdata) && !rvalid; endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; mgmt.rd && mgmt.addr != 5'h00 && !(mgmt.addr inside {[5'h12:5'h16]}) |=> rdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_upper; mgmt.rd && mgmt.addr inside {[5'h13:5'h15]} |=> rdata[15:8] == 8'h00; endproperty
    a_upper: assert property (p_upper) else $error("counter upper bits set");
    property p_clear; rd13 ##1 !evt.rx_error ##1 rd13 |=> rdata == 16'h0000; endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");
    property p_bcast; hit && mgmt.addr == 5'h16 |=> bcast_en == $past(mgmt.wdata[0]); endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast enable wrong");
    property p_tx; hit && mgmt.addr == 5'h12 |=> ctrl.tx_disable == $past(mgmt.wdata[15]); endproperty
    a_tx: assert property (p_tx) else $error("transmit disable wrong");
    property p_stable; (!mgmt.wr)[*3] |=> $stable(ctrl); endproperty
    a_stable: assert property (p_stable) else $error("controls moved");
    property p_live; evt.ten_link_active[*3] ##0 (mgmt.rd && mgmt.addr == 5'h16) |=> rdata[6]; endproperty
    a_live: assert property (p_live) else $error("link status missing");
    // a read in between would clear the flag before it is looked at
    property p_eof; evt.eof_error ##1 !(mgmt.rd && mgmt.addr == 5'h16) ##1 (mgmt.rd && mgmt.addr == 5'h16)
        |=> rdata[8]; endproperty
    a_eof: assert property (p_eof) else $error("eof flag missing");
endmodule

bind pecs_regs pecs_regs_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt(mgmt), .evt(evt), .rdata(rdata),
    .rvalid(rvalid), .bcast_en(bcast_en), .ctrl(ctrl));

/* File: pecs_mgmt_host.sv */
`timescale 1ns/1ps
module pecs_mgmt_host (
    input  wire logic                           clk_sys,
    output pecs_pkg::pecs_mgmt_t                mgmt,
    input  wire logic [pecs_pkg::DATA_W-1:0]    rdata
);
    // ************************************************************
    // station manager, one request per call
    // ************************************************************
    // accept high means the write is addressed to this phy
    logic accept = 1'b1;
    initial mgmt = '0;

    task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys);
        mgmt <= '{wr: w, rd: !w, bcast: accept, addr: a, wdata: d};
        @(posedge clk_sys);
        mgmt.wr <= 1'b0;
        mgmt.rd <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic soft_reset();
        logic [15:0] q;
        access(1'b1, 5'h00, 16'h8000, q);
    endtask
endmodule

/* File: phy_ext_ctrl_status_regs_bench.sv */
`timescale 1ns/1ps
module phy_ext_ctrl_status_regs_bench;
    logic                       clk_sys = 1'b0;
    logic                       rst_n = 1'b0;
    pecs_pkg::pecs_evt_t        evt = '0;
    pecs_pkg::pecs_mgmt_t       mgmt;
    logic [15:0]                rdata;
    logic                       rvalid;
    logic                       bcast_en;
    pecs_pkg::pecs_ctrl_t       ctrl;
    logic [15:0]                q;
    int                         num_errors = 0;
    int                         checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    pecs_mgmt_host host (.clk_sys(clk_sys), .mgmt(mgmt), .rdata(rdata));
    pecs_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt(mgmt), .evt(evt), .rdata(rdata), .rvalid(rvalid),
        .bcast_en(bcast_en), .ctrl(ctrl));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_ctrl(input logic [15:0] byp, input logic [15:0] ten);
        logic [19:0] e;
        e = {byp[15:9], byp[7:1], ten[15:10]};
        checks++;
        if (ctrl !== e) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, ctrl, e);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        host.access(1'b0, a, 16'h0000, q);
        chk_data(q, exp);
        chk_data({15'h0000, rvalid}, 16'h0001);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, q);
    endtask
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            @(posedge clk_sys) evt[b] <= 1'b1;
            @(posedge clk_sys) evt[b] <= 1'b0;
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rd_chk(5'h12, 16'h0088);
        rd_chk(5'h16, 16'h3200);
        for (int i = 0; i < 3; i++) rd_chk(5'h13 + i[4:0], 16'h0000);
        chk_ctrl(16'h0088, 16'h3200);
    endtask
    task automatic t_ctrl();
        wr(5'h12, 16'hffff);
        wr(5'h16, 16'hfe01);
        repeat (3) @(posedge clk_sys);
        chk_ctrl(16'hfefe, 16'hfe01);
        rd_chk(5'h12, 16'hfefe);
        rd_chk(5'h16, 16'hfe01);
        chk_data({15'h0000, bcast_en}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            wr(5'h16, {4'h3, i[1:0], 10'h200});
            repeat (3) @(posedge clk_sys);
            chk_ctrl(16'hfefe, {4'h3, i[1:0], 10'h200});
        end
    endtask
    task automatic t_counters();
        for (int i = 0; i < 3; i++) pulse(5 - i, i + 1);
        rd_chk(5'h13, 16'h0001);
        rd_chk(5'h13, 16'h0000);
        rd_chk(5'h14, 16'h0002);
        rd_chk(5'h15, 16'h0003);
        pulse(4, 260);
        rd_chk(5'h14, 16'h00ff);
    endtask
    task automatic t_flags();
        @(posedge clk_sys) evt[2:0] <= 3'h7;
        @(posedge clk_sys) evt[2:1] <= 2'h0;
        rd_chk(5'h16, 16'h3bc0);
        rd_chk(5'h16, 16'h3a40);
        @(posedge clk_sys) evt[0] <= 1'b0;
    endtask
    task automatic t_soft();
        wr(5'h12, 16'hffff);
        wr(5'h16, 16'hfe01);
        host.soft_reset();
        rd_chk(5'h12, 16'h00fa);
        rd_chk(5'h16, 16'hfe01);
        wr(5'h16, 16'h0000);
        host.soft_reset();
        rd_chk(5'h12, 16'h0088);
        rd_chk(5'h16, 16'h3000);
    endtask
    task automatic t_bcast();
        host.accept = 1'b0;
        wr(5'h12, 16'h0004);
        rd_chk(5'h12, 16'h0088);
        host.accept = 1'b1;
        wr(5'h16, 16'h3001);
        host.accept = 1'b0;
        // a broadcast write replaces every writable bit, sticky defaults included
        wr(5'h12, 16'h0004);
        rd_chk(5'h12, 16'h0004);
        rd_chk(5'h05, 16'h0000);
        host.accept = 1'b1;
    endtask

    task automatic stop_test();
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_ctrl();
        t_counters();
        t_flags();
        t_soft();
        t_bcast();
        stop_test();
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule
